/* File: rtl/fwp_defs.svh */
// offsets, field positions, reset values and block counts
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH
`define FWP_OFS_STATUS 12'h000
`define FWP_OFS_FUNC 12'h004
`define FWP_OFS_CMD 12'h008
`define FWP_OFS_RESULT 12'h00C
`define FWP_OFS_PINS 12'h010
`define FWP_ST_LATCH 1
`define FWP_ST_LEVEL_LO 2
`define FWP_ST_QUAD 6
`define FWP_ST_LOCK 7
`define FWP_FN_BOTTOM 1
`define FWP_FN_PPAUSE 2
`define FWP_FN_EPAUSE 3
`define FWP_FN_ROWLOCK_LO 4
`define FWP_STATUS_RESET 8'h00
`define FWP_FUNC_RESET 8'h00
`define FWP_NUM_BLOCKS 128
`define FWP_BLOCK_BITS 7
`endif

/* File: rtl/fwp_pkg.sv */
// types for the flash write-protect block
package fwp_pkg;
    typedef enum logic [3:0] {
        FWP_CMD_NONE = 4'h0,
        FWP_CMD_LATCH_SET = 4'h1,
        FWP_CMD_LATCH_CLR = 4'h2,
        FWP_CMD_STATUS_WR = 4'h3,
        FWP_CMD_FUNC_WR = 4'h4,
        FWP_CMD_PROGRAM = 4'h5,
        FWP_CMD_ERASE_4K = 4'h6,
        FWP_CMD_ERASE_32K = 4'h7,
        FWP_CMD_ERASE_64K = 4'h8,
        FWP_CMD_ERASE_ALL = 4'h9,
        FWP_CMD_ROW_PROGRAM = 4'hA,
        FWP_CMD_SUSPEND = 4'hB,
        FWP_CMD_RESUME = 4'hC,
        FWP_CMD_DONE = 4'hD
    } fwp_cmd_t;
    typedef enum logic [2:0] {
        FWP_OP_IDLE = 3'b001,
        FWP_OP_PROG = 3'b010,
        FWP_OP_ERASE = 3'b100
    } fwp_op_t;
endpackage

/* File: rtl/fwp_range.sv */
// decodes the protected block range and tests a target span
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_range
    import fwp_pkg::*;
(
    input wire logic [3:0] level,
    input wire logic bottom,
    input wire logic [6:0] spanLo,
    input wire logic [6:0] spanHi,
    output logic hit
);
    logic [7:0] count;
    logic [7:0] protLo;
    logic [7:0] protHi;
    // level 1..7 gives 1,2,4..64 blocks, 8..15 all
    assign count = level[3] ? 8'h80 :
        (level[2:0] == 3'h0) ? 8'h00 : 8'(8'h01 << (level[2:0] - 3'h1));
    // top anchors at block 127, bottom at block 0
    assign protLo = bottom ? 8'h00 : 8'(8'h80 - count);
    assign protHi = bottom ? 8'(count - 8'h01) : 8'h7F;
    // any overlap refuses the whole span
    assign hit = (count != 8'h00) && ({1'b0, spanHi} >= protLo) && ({1'b0, spanLo} <= protHi);
endmodule

/* File: rtl/fwp_top.sv */
// write-protection and function register logic with an AHB-Lite slave
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_top
    import fwp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic writeProtect_n,
    input wire logic pause_n,
    input wire logic dataLine2In,
    input wire logic dataLine3In,
    output logic quadLinesEnable,
    output logic writeProtectActive,
    output logic pauseActive,
    output logic [1:0] dataLineIn,
    output logic opStart,
    output logic [2:0] opKind
);
    import fwp_pkg::*;

    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] func_q;
    logic [7:0] func_d;
    fwp_op_t op_q;
    fwp_op_t op_d;
    logic opPaused_q;
    logic opPaused_d;
    logic [2:0] result_q;
    logic [2:0] result_d;
    logic opStart_q;
    logic [2:0] opKind_q;
    logic [3:0] pinSync1_q;
    logic [3:0] pinSync2_q;
    logic wrPend_q;
    logic [11:0] wrAddr_q;
    logic [31:0] hrdata_q;

    wire accept = hsel && hready && htrans[1];
    wire wrNow = wrPend_q;
    wire selCmd = wrNow && (wrAddr_q == `FWP_OFS_CMD);
    wire [3:0] cmdCode = hwdata[27:24];
    wire [22:0] cmdAddr = hwdata[22:0];
    wire latch = status_q[`FWP_ST_LATCH];
    wire lockBit = status_q[`FWP_ST_LOCK];
    wire [3:0] level = status_q[`FWP_ST_LEVEL_LO +: 4];
    wire wpSync = pinSync2_q[0];
    wire statusLocked = lockBit && !wpSync;
    wire busy = (op_q != FWP_OP_IDLE);

    // erase codes that work on one block
    function automatic logic eraseCode(input logic [3:0] code);
        logic res;
        res = 1'b0;
        case (code)
            FWP_CMD_ERASE_4K, FWP_CMD_ERASE_32K, FWP_CMD_ERASE_64K: begin
                res = 1'b1;
            end
            default: begin
                res = 1'b0;
            end
        endcase
        return res;
    endfunction

    // codes that need the write latch and an idle array
    function automatic logic latchCode(input logic [3:0] code);
        logic res;
        res = 1'b0;
        case (code)
            FWP_CMD_STATUS_WR, FWP_CMD_FUNC_WR, FWP_CMD_PROGRAM, FWP_CMD_ERASE_ALL,
                FWP_CMD_ROW_PROGRAM: begin
                res = 1'b1;
            end
            default: begin
                res = eraseCode(code);
            end
        endcase
        return res;
    endfunction

    // block index from the upper address bits
    wire [6:0] tgtBlock = cmdAddr[22:16];
    wire isErase = eraseCode(cmdCode);
    wire isProg = (cmdCode == FWP_CMD_PROGRAM);
    wire protHit;

    fwp_range uRange (
        .level(level),
        .bottom(func_q[`FWP_FN_BOTTOM]),
        .spanLo(tgtBlock),
        .spanHi(tgtBlock),
        .hit(protHit)
    );

    wire [1:0] rowSel = cmdAddr[9:8];
    wire rowLocked = func_q[`FWP_FN_ROWLOCK_LO + 32'(rowSel)];

    wire goProg = selCmd && latch && !busy && isProg && !protHit;
    wire goErase = selCmd && latch && !busy && isErase && !protHit;
    wire goAll = selCmd && latch && !busy && (cmdCode == FWP_CMD_ERASE_ALL) &&
        (level == 4'h0);
    wire goRow = selCmd && latch && !busy && (cmdCode == FWP_CMD_ROW_PROGRAM) &&
        !rowLocked;
    wire goStatus = selCmd && latch && !busy && (cmdCode == FWP_CMD_STATUS_WR) &&
        !statusLocked;
    wire goFunc = selCmd && latch && !busy && (cmdCode == FWP_CMD_FUNC_WR);
    wire goSuspend = selCmd && (cmdCode == FWP_CMD_SUSPEND) && busy && !opPaused_q;
    wire goResume = selCmd && (cmdCode == FWP_CMD_RESUME) && opPaused_q;
    wire goDone = selCmd && (cmdCode == FWP_CMD_DONE) && busy && !opPaused_q;
    wire anyWrite = goProg || goErase || goAll || goRow || goStatus || goFunc;
    wire isWriteCmd = selCmd && latchCode(cmdCode);

    always_comb begin
        status_d = status_q;
        if (selCmd && (cmdCode == FWP_CMD_LATCH_SET)) begin
            status_d[`FWP_ST_LATCH] = 1'b1;
        end
        if (selCmd && (cmdCode == FWP_CMD_LATCH_CLR)) begin
            status_d[`FWP_ST_LATCH] = 1'b0;
        end
        if (goStatus) begin
            status_d[7:2] = hwdata[7:2];
        end
        if (anyWrite || goDone) begin
            status_d[`FWP_ST_LATCH] = 1'b0;
        end
        status_d[0] = busy;
    end

    always_comb begin
        func_d = func_q;
        if (goFunc) begin
            // one-time bits only move from zero to one
            func_d[`FWP_FN_BOTTOM] = func_q[`FWP_FN_BOTTOM] | hwdata[`FWP_FN_BOTTOM];
            func_d[7:4] = func_q[7:4] | hwdata[7:4];
        end
        func_d[`FWP_FN_PPAUSE] = opPaused_d && (op_d == FWP_OP_PROG);
        func_d[`FWP_FN_EPAUSE] = opPaused_d && (op_d == FWP_OP_ERASE);
        func_d[0] = 1'b0;
    end

    always_comb begin
        op_d = op_q;
        opPaused_d = opPaused_q;
        unique case (op_q)
            FWP_OP_IDLE: begin
                if (goProg || goRow) begin
                    op_d = FWP_OP_PROG;
                end
                if (goErase || goAll) begin
                    op_d = FWP_OP_ERASE;
                end
            end
            FWP_OP_PROG, FWP_OP_ERASE: begin
                if (goSuspend) begin
                    opPaused_d = 1'b1;
                end
                if (goResume) begin
                    opPaused_d = 1'b0;
                end
                if (goDone) begin
                    op_d = FWP_OP_IDLE;
                end
            end
            default: begin
                op_d = FWP_OP_IDLE;
                opPaused_d = 1'b0;
            end
        endcase
    end

    // result: bit0 accepted, bit1 refused, bit2 write latch missing
    always_comb begin
        result_d = result_q;
        if (isWriteCmd) begin
            result_d = {!latch, !anyWrite, anyWrite};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_q <= `FWP_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            func_q <= `FWP_FUNC_RESET;
        end else begin
            func_q <= func_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            op_q <= FWP_OP_IDLE;
        end else begin
            op_q <= op_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            opPaused_q <= 1'b0;
        end else begin
            opPaused_q <= opPaused_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            result_q <= 3'h0;
        end else begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            opStart_q <= 1'b0;
            opKind_q <= 3'h0;
        end else begin
            opStart_q <= goProg || goErase || goAll || goRow;
            opKind_q <= {goAll, goErase, goProg || goRow};
        end
    end

    // pin synchronisers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinSync1_q <= 4'hF;
            pinSync2_q <= 4'hF;
        end else begin
            pinSync1_q <= {dataLine3In, dataLine2In, pause_n, writeProtect_n};
            pinSync2_q <= pinSync1_q;
        end
    end

    // quad bit selects data or control role of these outputs; the status lock reads the protect pin in either mode
    assign quadLinesEnable = status_q[`FWP_ST_QUAD];
    assign writeProtectActive = !quadLinesEnable && !pinSync2_q[0];
    assign pauseActive = !quadLinesEnable && !pinSync2_q[1];
    assign dataLineIn = quadLinesEnable ? pinSync2_q[3:2] : 2'b00;

    // bus slave: zero wait states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 12'h000;
        end else begin
            wrPend_q <= accept && hwrite;
            wrAddr_q <= haddr;
        end
    end

    wire [31:0] rdMux =
        (haddr == `FWP_OFS_STATUS) ? {24'h000000, status_q} :
        (haddr == `FWP_OFS_FUNC) ? {24'h000000, func_q} :
        (haddr == `FWP_OFS_RESULT) ? {29'h00000000, result_q} :
        (haddr == `FWP_OFS_PINS) ? {28'h0000000, pinSync2_q} : 32'h00000000;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata_q <= 32'h00000000;
        end else if (accept && !hwrite) begin
            hrdata_q <= rdMux;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign opStart = opStart_q;
    assign opKind = opKind_q;
endmodule

/* File: dv/fwp_top_checker.sv */
// assertions on the write-protect block ports
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_top_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic writeProtect_n,
    input wire logic pause_n,
    input wire logic quadLinesEnable,
    input wire logic writeProtectActive,
    input wire logic pauseActive,
    input wire logic [1:0] dataLineIn,
    input wire logic opStart,
    input wire logic [2:0] opKind
);
    logic cmdWr;
    assign cmdWr = hsel && hwrite && htrans[1] && haddr == `FWP_OFS_CMD;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_quad_ctrl: assert property (quadLinesEnable |-> !writeProtectActive && !pauseActive)
        else $error("control pin active in quad mode");
    a_quad_data: assert property (!quadLinesEnable |-> dataLineIn == 2'h0)
        else $error("data lines live without quad");
    a_wp_release: assert property (writeProtect_n [*3] |=> !writeProtectActive)
        else $error("protect active with pin high");
    a_pause_hold: assert property ((!pause_n && !quadLinesEnable) [*4] |-> pauseActive)
        else $error("pause not active");
    a_start_pulse: assert property (opStart |=> !opStart)
        else $error("two starts in a row");
    a_start_kind: assert property (opStart |-> opKind inside {3'h1, 3'h2, 3'h4})
        else $error("bad operation kind");
    a_start_cause: assert property (opStart |-> $past(cmdWr, 2) || $past(cmdWr, 3))
        else $error("start without command");
    a_quad_cause: assert property ($changed(quadLinesEnable) |-> $past(cmdWr, 2))
        else $error("quad bit changed without write");
endmodule

bind fwp_top fwp_top_checker i_chk (.*);

/* File: dv/fwp_pin_model.sv */
// board-side model driving control and data pins
`timescale 1ns/1ps
module fwp_pin_model (
    input wire logic quad,
    input wire logic ctlLow,
    input wire logic d2,
    input wire logic d3,
    output logic wpN,
    output logic pauseN,
    output logic line2,
    output logic line3
);
    // control pins carry control levels while quad is off, data otherwise; data pins carry inverted data while quad is off
    assign wpN = quad ? d2 : !ctlLow;
    assign pauseN = quad ? d3 : !ctlLow;
    assign line2 = quad ? d2 : !d2;
    assign line3 = quad ? d3 : !d3;
endmodule

/* File: dv/testbench.sv */
// testbench for the write-protect block
`timescale 1ns/1ps
`include "fwp_defs.svh"
module testbench;
    import fwp_pkg::*;
    logic mclk, nrst, hsel, hwrite, hreadyout, quad, ctlLow, d2, d3;
    logic wpN, pauseN, line2, line3, wpAct, pauseAct, opStart;
    logic [11:0] haddr;
    logic [1:0] htrans, dataLineIn;
    logic [2:0] opKind;
    logic [31:0] hwdata, hrdata, rd;
    int nErrors = 0;
    int nTests = 0;
    int nStarts = 0;
    logic [2:0] kindSeen;
    fwp_top i_dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .writeProtect_n(wpN), .pause_n(pauseN),
        .dataLine2In(line2), .dataLine3In(line3), .quadLinesEnable(quad),
        .writeProtectActive(wpAct), .pauseActive(pauseAct), .dataLineIn(dataLineIn),
        .opStart(opStart), .opKind(opKind));
    fwp_pin_model i_pins (.quad(quad), .ctlLow(ctlLow), .d2(d2), .d3(d3), .wpN(wpN),
        .pauseN(pauseN), .line2(line2), .line3(line3));
    // counts operation starts and keeps the last kind
    always @(posedge mclk) begin
        if (opStart === 1'b1) begin
            nStarts <= nStarts + 1;
            kindSeen <= opKind;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic endOfTest;
        if (nErrors == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; hsel stays up, idle htrans ends it
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [22:0] a);
        bus(`FWP_OFS_CMD, 1'b1, {4'h0, c, 1'b0, a});
    endtask
    task automatic lw(input logic [3:0] c, input logic [22:0] a);
        cmd(4'h1, 23'h0);
        cmd(c, a);
    endtask
    task automatic op(input logic [3:0] c, input logic [22:0] a, input logic ok);
        int s0;
        logic [31:0] kind;
        s0 = nStarts;
        kind = (c == 4'h9) ? 32'h4 : ((c == 4'h5 || c == 4'hA) ? 32'h1 : 32'h2);
        lw(c, a);
        bus(`FWP_OFS_RESULT, 1'b0, 32'h0);
        cmp(rd & 32'h3, ok ? 32'h1 : 32'h2);
        cmp(32'(nStarts - s0), ok ? 32'h1 : 32'h0);
        if (ok) cmp({29'h0, kindSeen}, kind);
        if (ok) cmd(4'hD, 23'h0);
    endtask
    // edge blocks of every level, program and all erase sizes in turn
    task automatic levels(input logic bot);
        int n;
        logic [6:0] b;
        for (int l = 0; l < 16; l++) begin
            n = l == 0 ? 0 : (l > 7 ? 128 : 1 << (l - 1));
            lw(4'h3, 23'(l << 2));
            b = 7'(bot ? n - 1 : 128 - n);
            if (n > 0) op(4'(5 + l % 4), {b, 16'h0}, 1'b0);
            b = 7'(bot ? n : 127 - n);
            if (n < 128) op(4'(5 + l % 4), {b, 16'h0}, 1'b1);
        end
    endtask
    initial begin
        #2_000_000;
        nErrors++;
        endOfTest;
    end
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ctlLow = 1'b0;
        d2 = 1'b0;
        d3 = 1'b0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        bus(`FWP_OFS_FUNC, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        cmd(4'h3, 23'h80);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        cmd(4'h5, 23'h0);
        bus(`FWP_OFS_RESULT, 1'b0, 32'h0);
        cmp(rd & 32'h5, 32'h4);
        cmd(4'h1, 23'h0);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'h2, 32'h2);
        cmd(4'h2, 23'h0);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'h2, 32'h0);
        lw(4'h3, 23'h80);
        ctlLow <= 1'b1;
        repeat (4) @(posedge mclk);
        cmp({30'h0, wpAct, pauseAct}, 32'h3);
        lw(4'h3, 23'h84);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'hFC, 32'h80);
        ctlLow <= 1'b0;
        repeat (4) @(posedge mclk);
        lw(4'h3, 23'h04);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'hFC, 32'h04);
        ctlLow <= 1'b1;
        repeat (4) @(posedge mclk);
        lw(4'h3, 23'h08);
        bus(`FWP_OFS_STATUS, 1'b0, 32'h0);
        cmp(rd & 32'hFC, 32'h08);
        op(4'h9, 23'h0, 1'b0);
        levels(1'b0);
        lw(4'h3, 23'h0);
        op(4'h9, 23'h0, 1'b1);
        lw(4'h4, 23'h13);
        bus(`FWP_OFS_FUNC, 1'b0, 32'h0);
        cmp(rd, 32'h12);
        lw(4'h4, 23'h0);
        bus(`FWP_OFS_FUNC, 1'b0, 32'h0);
        cmp(rd, 32'h12);
        levels(1'b1);
        lw(4'h3, 23'h0);
        op(4'hA, 23'h000, 1'b0);
        op(4'hA, 23'h100, 1'b1);
        for (int k = 0; k < 2; k++) begin
            lw(k ? 4'h6 : 4'h5, 23'h0);
            cmd(4'hB, 23'h0);
            bus(`FWP_OFS_FUNC, 1'b0, 32'h0);
            cmp(rd & 32'hC, k ? 32'h8 : 32'h4);
            cmd(4'hC, 23'h0);
            bus(`FWP_OFS_FUNC, 1'b0, 32'h0);
            cmp(rd & 32'hC, 32'h0);
            cmd(4'hD, 23'h0);
        end
        bus(12'h020, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        lw(4'h3, 23'h40);
        d2 <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        cmp({29'h0, quad, dataLineIn}, 32'h5);
        endOfTest;
    end
endmodule
